/* File: ipesch_pkg.sv */
// Purpose: Shared constants and types of the idle pump exercise scheduler
// Assumes: 25 MHz system clock, APB register access with 32-bit data
// Notes: Times are counted in 100 ms ticks
package ipesch_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_IDLE = 8'h04;
    localparam logic [7:0] REG_TOD = 8'h08;
    localparam logic [7:0] REG_RUNTIME = 8'h0c;
    localparam logic [7:0] REG_SPEED = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    // Control field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_KEY_BIT = 2;
    localparam int CTRL_IMM_BIT = 3;
    // Time of day field positions
    localparam int TOD_MIN_LSB = 0;
    localparam int TOD_HOUR_LSB = 8;
    // Status field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_IDLE_BIT = 4;
    localparam int STAT_IMM_BIT = 5;
    localparam int STAT_CNT_LSB = 8;
    // Exercise selector codes
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_IDLE = 2'h1;
    localparam logic [1:0] SEL_TIMED = 2'h2;
    // Operating mode codes on the mode input
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_AUTO = 2'h2;
    // Reset values and limits
    localparam logic [1:0] SEL_RST = SEL_OFF;
    localparam logic [7:0] IDLE_HOURS_RST = 8'h18;
    localparam logic [7:0] IDLE_HOURS_MAX = 8'ha8;
    localparam logic [4:0] TOD_HOUR_RST = 5'h00;
    localparam logic [5:0] TOD_MIN_RST = 6'h00;
    localparam logic [12:0] RUNTIME_RST = 13'h0032;
    localparam logic [12:0] RUNTIME_MAX = 13'h1770;
    localparam logic [15:0] SPEED_RST = 16'h01f4;
    // Time base
    localparam int CLK_KHZ = 25000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES_DFLT = CLK_KHZ * TICK_MS;
    localparam int TICKS_PER_HOUR_INT = 3600 * 1000 / TICK_MS;
    localparam logic [23:0] TICKS_PER_HOUR = 24'(TICKS_PER_HOUR_INT);
    // Scheduler states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_TOD,
        ST_RAMP_UP,
        ST_HOLD,
        ST_RAMP_DOWN
    } ipesch_state_e;
endpackage

/* File: ipesch_tick.sv */
// Purpose: Divides the system clock down to a one-cycle time base tick
// Assumes: DIV of two or more
// Notes: Free running from reset release
module ipesch_tick
    import ipesch_pkg::*;
#(
    parameter int DIV = TICK_CYCLES_DFLT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);
    logic [31:0] div_reg;
    logic wrap;

    assign wrap = (div_reg == 32'(DIV - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 32'h0;
            tick_o <= 1'b0;
        end else begin
            div_reg <= wrap ? 32'h0 : div_reg + 32'h1;
            tick_o <= wrap;
        end
    end
endmodule

/* File: ipesch_cnt.sv */
// Purpose: Saturating tick counter with a compare limit
// Assumes: Clear has priority over counting
// Notes: Done is combinational from the count
module ipesch_cnt
    import ipesch_pkg::*;
#(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic [W-1:0] limit_i,
    output logic done_o
);
    logic [W-1:0] cnt_reg;

    assign done_o = (cnt_reg >= limit_i);

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_reg <= '0;
        end else if (en_i && !done_o) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

/* File: ipesch_top.sv */
// Purpose: Exercises an idle pump at a set speed for a set time
// Assumes: Ramp control reports reaching speed and standstill
// Notes: Registers over APB, no wait states per transfer
//
// Operation
// - The periodic exercise run is started only while the drive is in automatic mode.
// - The run is started whether or not the system start command is enabled.
// - The run drives the configured speed, 500 rpm by default, kept within motor limits.
// - The speed is held for the run duration, 5.0 s by default, plus the ramp times.
// - Pumps stopped by the sleep function are exercised as well.
// - Switching the operating mode to OFF aborts a run at once.
// - The selector reads 0 for disabled, 1 for after idle period, 2 for at a time of day.
// - A run is due once the pump has not started for the idle period, 24 h by default.
// - A run starts, runs and stops the pump and withholds it from closed-loop control.
// - In time of day mode the due run waits for the set hours and minutes, 00:00 default.
// - The immediate run setting or its assigned panel key starts a run at once.
module ipesch_top
    import ipesch_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [1:0] OP_MODE_I,
    input wire logic PUMP_RUNNING_I,
    input wire logic SLEEP_I,
    input wire logic SYS_START_EN_I,
    input wire logic ASSIGNABLE_PANEL_KEY_I,
    input wire logic AT_SPEED_I,
    input wire logic MOTOR_STOPPED_I,
    input wire logic [15:0] MOTOR_MIN_RPM_I,
    input wire logic [15:0] MOTOR_MAX_RPM_I,
    input wire logic [4:0] TOD_HOUR_I,
    input wire logic [5:0] TOD_MIN_I,
    output logic RUN_REQ_O,
    output logic [15:0] SPEED_SET_O,
    output logic CTRL_WITHHELD_O
);
    // Register state
    logic [1:0] sel_reg;
    logic key_assign_reg;
    logic imm_reg;
    logic imm_next;
    logic [7:0] idle_hours_reg;
    logic [4:0] tod_hour_reg;
    logic [5:0] tod_min_reg;
    logic [12:0] runtime_reg;
    logic [15:0] speed_reg;
    logic [7:0] run_cnt_reg;
    ipesch_state_e state_reg;
    ipesch_state_e state_next;

    // Bus decode
    logic setup;
    logic wr_en;
    logic hit_ctrl;
    logic hit_idle;
    logic hit_tod;
    logic hit_runtime;
    logic hit_speed;
    logic hit_status;
    logic mapped;
    logic [31:0] rd_data;
    logic [31:0] status_word;
    logic [7:0] wr_hours;
    logic [12:0] wr_runtime;

    // Scheduler terms
    logic tick;
    logic is_auto;
    logic is_off;
    logic key_press;
    logic imm_set;
    logic idle_done;
    logic idle_clr;
    logic idle_en;
    logic run_done;
    logic run_clr;
    logic tod_match;
    logic due;
    logic running;
    logic [23:0] idle_limit;
    logic [15:0] speed_clamped;

    assign setup = PSEL_I && !PENABLE_I;
    assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    assign hit_ctrl = (PADDR_I == REG_CTRL);
    assign hit_idle = (PADDR_I == REG_IDLE);
    assign hit_tod = (PADDR_I == REG_TOD);
    assign hit_runtime = (PADDR_I == REG_RUNTIME);
    assign hit_speed = (PADDR_I == REG_SPEED);
    assign hit_status = (PADDR_I == REG_STATUS);
    assign mapped = hit_ctrl || hit_idle || hit_tod || hit_runtime || hit_speed || hit_status;

    assign wr_hours = (PWDATA_I[7:0] > IDLE_HOURS_MAX) ? IDLE_HOURS_MAX : PWDATA_I[7:0];
    assign wr_runtime = (PWDATA_I[12:0] > RUNTIME_MAX) ? RUNTIME_MAX : PWDATA_I[12:0];

    assign status_word = {16'h0, run_cnt_reg, 2'h0, imm_reg, idle_done, 1'b0, state_reg};

    assign rd_data = hit_ctrl ? {28'h0, imm_reg, key_assign_reg, sel_reg} :
                     hit_idle ? {24'h0, idle_hours_reg} :
                     hit_tod ? {19'h0, tod_hour_reg, 2'h0, tod_min_reg} :
                     hit_runtime ? {19'h0, runtime_reg} :
                     hit_speed ? {16'h0, speed_reg} :
                     hit_status ? status_word : 32'h0;

    // APB answer one cycle after setup
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0;
        end else begin
            PREADY_O <= setup;
            PSLVERR_O <= setup && !mapped;
            PRDATA_O <= (setup && !PWRITE_I) ? rd_data : 32'h0;
        end
    end

    // Configuration registers
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            sel_reg <= SEL_RST;
            key_assign_reg <= 1'b0;
            idle_hours_reg <= IDLE_HOURS_RST;
            tod_hour_reg <= TOD_HOUR_RST;
            tod_min_reg <= TOD_MIN_RST;
            runtime_reg <= RUNTIME_RST;
            speed_reg <= SPEED_RST;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                sel_reg <= PWDATA_I[CTRL_SEL_LSB+:2];
                key_assign_reg <= PWDATA_I[CTRL_KEY_BIT];
            end
            if (hit_idle) begin
                idle_hours_reg <= wr_hours;
            end
            if (hit_tod) begin
                tod_hour_reg <= PWDATA_I[TOD_HOUR_LSB+:5];
                tod_min_reg <= PWDATA_I[TOD_MIN_LSB+:6];
            end
            if (hit_runtime) begin
                runtime_reg <= wr_runtime;
            end
            if (hit_speed) begin
                speed_reg <= PWDATA_I[15:0];
            end
        end
    end

    assign is_auto = (OP_MODE_I == MODE_AUTO);
    assign is_off = (OP_MODE_I == MODE_OFF);
    assign key_press = ASSIGNABLE_PANEL_KEY_I && key_assign_reg;
    assign imm_set = (wr_en && hit_ctrl && PWDATA_I[CTRL_IMM_BIT]) || key_press;
    // Set wins over the clear taken at run start
    // Cleared in both states that start a run, so one request gives one run
    assign imm_next = imm_set || (imm_reg && (state_reg != ST_IDLE) &&
                                  (state_reg != ST_WAIT_TOD) && !is_off);

    ipesch_tick #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .tick_o(tick)
    );

    // Idle time restarts on any start
    assign idle_clr = PUMP_RUNNING_I || running || (state_reg == ST_RAMP_DOWN);
    assign idle_en = tick;
    assign idle_limit = 24'(idle_hours_reg) * TICKS_PER_HOUR;

    ipesch_cnt #(
        .W(24)
    ) u_idle (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .clr_i(idle_clr),
        .en_i(idle_en),
        .limit_i(idle_limit),
        .done_o(idle_done)
    );

    assign run_clr = (state_reg != ST_HOLD);

    ipesch_cnt #(
        .W(13)
    ) u_run (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .clr_i(run_clr),
        .en_i(tick),
        .limit_i(runtime_reg),
        .done_o(run_done)
    );

    assign tod_match = (TOD_HOUR_I == tod_hour_reg) && (TOD_MIN_I == tod_min_reg);
    // Periodic run only in automatic mode
    assign due = is_auto && idle_done && !PUMP_RUNNING_I && (sel_reg != SEL_OFF);
    assign running = (state_reg == ST_RAMP_UP) || (state_reg == ST_HOLD);

    assign speed_clamped = (speed_reg < MOTOR_MIN_RPM_I) ? MOTOR_MIN_RPM_I :
                           (speed_reg > MOTOR_MAX_RPM_I) ? MOTOR_MAX_RPM_I : speed_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (imm_reg && !is_off) begin
                    state_next = ST_RAMP_UP;
                end else if (due && (sel_reg == SEL_IDLE)) begin
                    state_next = ST_RAMP_UP;
                end else if (due && (sel_reg == SEL_TIMED)) begin
                    state_next = ST_WAIT_TOD;
                end
            end
            ST_WAIT_TOD: begin
                if (imm_reg && !is_off) begin
                    state_next = ST_RAMP_UP;
                end else if (!due || (sel_reg != SEL_TIMED)) begin
                    state_next = ST_IDLE;
                end else if (tod_match) begin
                    state_next = ST_RAMP_UP;
                end
            end
            ST_RAMP_UP: begin
                if (AT_SPEED_I) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (run_done) begin
                    state_next = ST_RAMP_DOWN;
                end
            end
            ST_RAMP_DOWN: begin
                if (MOTOR_STOPPED_I) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (is_off) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            state_reg <= ST_IDLE;
            imm_reg <= 1'b0;
            run_cnt_reg <= 8'h0;
        end else begin
            state_reg <= state_next;
            imm_reg <= imm_next;
            if ((state_reg == ST_HOLD) && run_done) begin
                run_cnt_reg <= run_cnt_reg + 8'h1;
            end
        end
    end

    // Outputs toward ramp control
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            RUN_REQ_O <= 1'b0;
            SPEED_SET_O <= 16'h0;
            CTRL_WITHHELD_O <= 1'b0;
        end else begin
            RUN_REQ_O <= (state_next == ST_RAMP_UP) || (state_next == ST_HOLD);
            SPEED_SET_O <= speed_clamped;
            CTRL_WITHHELD_O <= (state_next == ST_RAMP_UP) || (state_next == ST_HOLD) ||
                               (state_next == ST_RAMP_DOWN);
        end
    end
endmodule

/* File: ipesch_monitor.sv */
// Purpose: Port checker for the pump exercise scheduler
// Assumes: One clock, synchronous active high reset
// Notes: Bound to the top module
module ipesch_monitor
    import ipesch_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [1:0] OP_MODE_I,
    input wire logic MOTOR_STOPPED_I,
    input wire logic [15:0] MOTOR_MIN_RPM_I,
    input wire logic [15:0] MOTOR_MAX_RPM_I,
    input wire logic RUN_REQ_O,
    input wire logic [15:0] SPEED_SET_O,
    input wire logic CTRL_WITHHELD_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);
    chk_off_abort: assert property (
        OP_MODE_I == MODE_OFF |=> !RUN_REQ_O && !CTRL_WITHHELD_O)
        else $error("run kept in off mode");
    chk_run_withheld: assert property (
        RUN_REQ_O |-> CTRL_WITHHELD_O) else $error("run without withhold");
    chk_start_pair: assert property (
        $rose(RUN_REQ_O) |-> $rose(CTRL_WITHHELD_O)) else $error("start not paired");
    chk_ramp_down: assert property (
        $fell(RUN_REQ_O) && $past(OP_MODE_I) != MODE_OFF |-> CTRL_WITHHELD_O)
        else $error("withhold lost before ramp down");
    chk_release_cause: assert property (
        $fell(CTRL_WITHHELD_O) |-> $past(MOTOR_STOPPED_I) || $past(OP_MODE_I) == MODE_OFF)
        else $error("withhold released early");
    chk_speed_limit: assert property (
        !$past(SYS_RST_I) && $stable(MOTOR_MIN_RPM_I) && $stable(MOTOR_MAX_RPM_I)
        |-> SPEED_SET_O >= MOTOR_MIN_RPM_I && SPEED_SET_O <= MOTOR_MAX_RPM_I)
        else $error("speed outside motor limits");
    chk_ready_after: assert property (
        PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no ready after setup");
    chk_ready_pulse: assert property (
        PREADY_O |=> !PREADY_O) else $error("ready longer than one cycle");
    chk_err_ready: assert property (
        PSLVERR_O |-> PREADY_O) else $error("error without ready");
    cover property ($fell(RUN_REQ_O) && $past(OP_MODE_I) == MODE_OFF);
    cover property ($fell(CTRL_WITHHELD_O) && $past(MOTOR_STOPPED_I));
    cover property (PSLVERR_O);
endmodule
bind ipesch_top ipesch_monitor ipesch_monitor_inst (.*);

/* File: ipesch_ramp_model.sv */
// Purpose: Behavioural ramp control facing the scheduler
// Assumes: Ramps take RAMP cycles
// Notes: Standstill only after a full ramp down
module ipesch_ramp_model #(
    parameter int RAMP = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic at_speed_o,
    output logic stopped_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
        end else if (run_i && cnt < RAMP) begin
            cnt <= cnt + 1;
        end else if (!run_i && cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign at_speed_o = run_i && (cnt == RAMP);
    assign stopped_o = (cnt == 0);
endmodule

/* File: ipesch_tb.sv */
// Purpose: Self-checking bench for the pump exercise scheduler
// Assumes: Tick of 4 cycles, idle period of 0 h in runs
// Notes: Ramp control is a behavioural model
module ipesch_tb
    import ipesch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK_I = 1'b0;
    logic SYS_RST_I = 1'b1;
    logic PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    logic [7:0] PADDR_I = 8'h00;
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
    logic PREADY_O, PSLVERR_O, RUN_REQ_O, CTRL_WITHHELD_O, AT_SPEED_I, MOTOR_STOPPED_I, er;
    logic [15:0] SPEED_SET_O;
    logic [1:0] OP_MODE_I = MODE_MANUAL;
    logic PUMP_RUNNING_I = 1'b0, SLEEP_I = 1'b1, SYS_START_EN_I = 1'b0;
    logic ASSIGNABLE_PANEL_KEY_I = 1'b0;
    logic [15:0] MOTOR_MIN_RPM_I = 16'h0064, MOTOR_MAX_RPM_I = 16'h0bb8;
    logic [4:0] TOD_HOUR_I = 5'h00;
    logic [5:0] TOD_MIN_I = 6'h00;
    int err_total = 0, check_count = 0;
    localparam int LV_RUN = 0;
    localparam int LV_HOLD = 1;
    localparam int LV_SPD = 2;
    always #20 MCLK_I = ~MCLK_I;
    ipesch_top #(.TICK_CYCLES(4)) ipesch_top_inst (.*);
    ipesch_ramp_model ipesch_ramp_model_inst (.clk_i(MCLK_I), .rst_i(SYS_RST_I),
        .run_i(RUN_REQ_O), .at_speed_o(AT_SPEED_I), .stopped_o(MOTOR_STOPPED_I));
    task cyc(input int n);
        repeat (n) @(posedge MCLK_I);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK_I);
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge MCLK_I);
        PENABLE_I <= 1'b1;
        do begin
            @(posedge MCLK_I);
        end while (PREADY_O !== 1'b1);
        rd = PRDATA_O;
        er = PSLVERR_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    function automatic logic lvl(input int k);
        case (k)
            LV_RUN: return RUN_REQ_O;
            LV_HOLD: return CTRL_WITHHELD_O;
            default: return AT_SPEED_I;
        endcase
    endfunction
    task automatic wlvl(input int k, input logic v);
        int n;
        n = 0;
        while (lvl(k) !== v && n < 100) begin
            @(posedge MCLK_I);
            n++;
        end
        chk(lvl(k), v);
    endtask
    task press;
        ASSIGNABLE_PANEL_KEY_I <= 1'b1;
        cyc(1);
        ASSIGNABLE_PANEL_KEY_I <= 1'b0;
        cyc(10);
    endtask
    task t_regs;
        rdchk(REG_CTRL, 32'h0);
        chk(er, 1'b0);
        rdchk(REG_IDLE, 32'h18);
        rdchk(REG_TOD, 32'h0);
        rdchk(REG_RUNTIME, 32'h32);
        rdchk(REG_SPEED, 32'h1f4);
        chk(SPEED_SET_O, 32'h1f4);
        rdchk(8'h18, 32'h0);
        chk(er, 1'b1);
        wr(REG_SPEED, 32'h1388);
        cyc(2);
        chk(SPEED_SET_O, 32'hbb8);
        wr(REG_SPEED, 32'h32);
        cyc(2);
        chk(SPEED_SET_O, 32'h64);
    endtask
    task t_cyclic;
        int n;
        n = 0;
        wr(REG_SPEED, 32'h320);
        wr(REG_RUNTIME, 32'h3);
        wr(REG_IDLE, 32'h0);
        wr(REG_CTRL, 32'h3);
        OP_MODE_I <= MODE_AUTO;
        cyc(20);
        chk(RUN_REQ_O, 1'b0);
        PUMP_RUNNING_I <= 1'b1;
        wr(REG_CTRL, {30'h0, SEL_IDLE});
        cyc(20);
        chk(RUN_REQ_O, 1'b0);
        OP_MODE_I <= MODE_MANUAL;
        PUMP_RUNNING_I <= 1'b0;
        cyc(20);
        chk(RUN_REQ_O, 1'b0);
        OP_MODE_I <= MODE_AUTO;
        wlvl(LV_RUN, 1'b1);
        chk(CTRL_WITHHELD_O, 1'b1);
        chk(SPEED_SET_O, 32'h320);
        wlvl(LV_SPD, 1'b1);
        while (RUN_REQ_O === 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        chk(n >= 8 && n <= 18, 1'b1);
        OP_MODE_I <= MODE_MANUAL;
        chk(CTRL_WITHHELD_O, 1'b1);
        wlvl(LV_HOLD, 1'b0);
        rdchk(REG_STATUS, 32'h110);
        chk(rd[15:8], 32'h1);
    endtask
    task t_off;
        OP_MODE_I <= MODE_AUTO;
        wlvl(LV_SPD, 1'b1);
        OP_MODE_I <= MODE_OFF;
        cyc(2);
        chk({RUN_REQ_O, CTRL_WITHHELD_O}, 2'b00);
        wr(REG_CTRL, 32'h0);
        OP_MODE_I <= MODE_MANUAL;
        cyc(8);
    endtask
    task t_imm;
        wr(REG_CTRL, 32'h8);
        wlvl(LV_RUN, 1'b1);
        wlvl(LV_HOLD, 1'b0);
        press;
        chk(RUN_REQ_O, 1'b0);
        wr(REG_CTRL, 32'h4);
        press;
        chk(RUN_REQ_O, 1'b1);
        wlvl(LV_HOLD, 1'b0);
    endtask
    task t_tod;
        wr(REG_TOD, 32'hc05);
        TOD_HOUR_I <= 5'h0b;
        TOD_MIN_I <= 6'h05;
        wr(REG_CTRL, {30'h0, SEL_TIMED});
        OP_MODE_I <= MODE_AUTO;
        cyc(20);
        chk(RUN_REQ_O, 1'b0);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[2:0], 32'h1);
        wr(REG_CTRL, 32'ha);
        wlvl(LV_RUN, 1'b1);
        wlvl(LV_HOLD, 1'b0);
        cyc(10);
        chk(RUN_REQ_O, 1'b0);
        TOD_HOUR_I <= 5'h0c;
        wlvl(LV_RUN, 1'b1);
        OP_MODE_I <= MODE_OFF;
        cyc(4);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        cyc(10);
        SYS_RST_I <= 1'b0;
        cyc(1);
        t_regs;
        t_cyclic;
        t_off;
        t_imm;
        t_tod;
        end_sim;
    end
    initial begin
        #400000;
        err_total++;
        end_sim;
    end
endmodule
